//--- hdl/ims_port.v
// Operation
// - one bit rate of three paces the master; the slave follows the bus clock.
// - master and slave each have their own enable.
// - in bus monitor mode the slave only logs traffic and never drives sda; a full log still holds scl low.
// - the slave answers its own 7-bit address, or a 10-bit one if chosen.
// - a 32-bit default word is sent whenever the transmit fifo is empty.
// - reads drain the transmit fifo first, then the default word bytes.
// - stored settings take effect only when the port is started again.
// - stored settings are readable back.
// - host fills the slave transmit fifo while the master reads it back.
// - the master reads a given count of bytes from a given address.
// - the master writes host bytes; the own slave logs them.
// - log entries carry start, stop, address and direction markers.
`timescale 1ns/1ns
`default_nettype none
`include "ims_consts.vh"
module ims_port (
   input wire i_clock,
   input wire i_sys_rst,
   input wire i_scl_in,
   output reg o_scl_out,
   output reg o_scl_oe,
   input wire i_sda_in,
   output reg o_sda_out,
   output reg o_sda_oe,
   input wire i_cfg_store,
   input wire [1:0] i_rate_sel,
   input wire i_master_en,
   input wire i_slave_en,
   input wire i_bus_monitor_mode,
   input wire [9:0] i_own_addr,
   input wire i_addr10,
   input wire [31:0] i_default_word,
   input wire i_run,
   output reg [1:0] o_cfg_rate,
   output reg o_cfg_master_en,
   output reg o_cfg_slave_en,
   output reg o_cfg_bus_monitor_mode,
   output reg [9:0] o_cfg_own_addr,
   output reg o_cfg_addr10,
   output reg [31:0] o_cfg_default_word,
   output reg o_running,
   input wire [7:0] i_txf_data,
   input wire i_txf_valid,
   output wire o_txf_ready,
   input wire i_mst_go,
   input wire i_mst_read,
   input wire [6:0] i_mst_addr,
   input wire [7:0] i_mst_len,
   input wire [7:0] i_mst_wdata,
   output reg o_mst_wtake,
   output reg [7:0] o_mst_rdata,
   output reg o_mst_rvalid,
   output reg o_mst_busy,
   output reg o_mst_nack,
   output wire [11:0] o_rxf_data,
   output wire o_rxf_valid,
   input wire i_rxf_ready
);
   localparam [31:0] Q100 = `IMS_QTR(`IMS_T100K_NS);
   localparam [31:0] Q400 = `IMS_QTR(`IMS_T400K_NS);
   localparam [31:0] Q1M = `IMS_QTR(`IMS_T1M_NS);
   localparam M_IDLE = 4'b0001;
   localparam M_START = 4'b0010;
   localparam M_BIT = 4'b0100;
   localparam M_STOP = 4'b1000;
   localparam S_IDLE = 6'b000001;
   localparam S_ADDR = 6'b000010;
   localparam S_ADDR2 = 6'b000100;
   localparam S_WR = 6'b001000;
   localparam S_RD = 6'b010000;
   localparam S_IGN = 6'b100000;

   // pins pass two flops before any use
   wire [1:0] pin_s;
   ims_sync #(.W(2)) u_sync (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_d({i_scl_in, i_sda_in}),
      .o_q(pin_s)
   );
   wire scl = pin_s[1];
   wire sda = pin_s[0];
   reg scl_d;
   reg sda_d;

   // settings that are live while the port runs
   reg [1:0] act_rate;
   reg act_men;
   reg act_sen;
   reg act_bm;
   reg [9:0] act_addr;
   reg act_a10;
   reg [31:0] act_dw;
   reg [`IMS_QW-1:0] q_lim;
   reg [`IMS_QW-1:0] qc;
   reg tick;

   always @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         o_cfg_rate <= `IMS_RATE_100K;
         o_cfg_master_en <= 1'b0;
         o_cfg_slave_en <= 1'b0;
         o_cfg_bus_monitor_mode <= 1'b0;
         o_cfg_own_addr <= 10'h000;
         o_cfg_addr10 <= 1'b0;
         o_cfg_default_word <= 32'h00000000;
         o_running <= 1'b0;
         act_rate <= `IMS_RATE_100K;
         act_men <= 1'b0;
         act_sen <= 1'b0;
         act_bm <= 1'b0;
         act_addr <= 10'h000;
         act_a10 <= 1'b0;
         act_dw <= 32'h00000000;
         q_lim <= Q100[`IMS_QW-1:0];
      end
      else
      begin
         if (i_cfg_store)
         begin
            o_cfg_rate <= i_rate_sel;
            o_cfg_master_en <= i_master_en;
            o_cfg_slave_en <= i_slave_en;
            o_cfg_bus_monitor_mode <= i_bus_monitor_mode;
            o_cfg_own_addr <= i_own_addr;
            o_cfg_addr10 <= i_addr10;
            o_cfg_default_word <= i_default_word;
         end
         o_running <= i_run;
         // copy only on a fresh start so a running bus never sees a change
         if (i_run & ~o_running)
         begin
            act_rate <= o_cfg_rate;
            act_men <= o_cfg_master_en;
            act_sen <= o_cfg_slave_en;
            act_bm <= o_cfg_bus_monitor_mode;
            act_addr <= o_cfg_own_addr;
            act_a10 <= o_cfg_addr10;
            act_dw <= o_cfg_default_word;
            case (o_cfg_rate)
               `IMS_RATE_400K: q_lim <= Q400[`IMS_QW-1:0];
               `IMS_RATE_1M: q_lim <= Q1M[`IMS_QW-1:0];
               default: q_lim <= Q100[`IMS_QW-1:0];
            endcase
         end
      end
   end

   // one quarter bit tick that paces the master; the slave follows bus edges
   always @(posedge i_clock)
   begin
      if (i_sys_rst | ~o_running)
      begin
         qc <= {`IMS_QW{1'b0}};
         tick <= 1'b0;
      end
      else if (qc == q_lim)
      begin
         qc <= {`IMS_QW{1'b0}};
         tick <= 1'b1;
      end
      else
      begin
         qc <= qc + 1'b1;
         tick <= 1'b0;
      end
   end

   // master
   reg [3:0] m_st;
   reg [1:0] m_q;
   reg [3:0] m_bit;
   reg [8:0] m_sh;
   reg [8:0] m_rx;
   reg m_rd;
   reg m_first;
   reg [7:0] m_left;
   reg m_scl_oe;
   reg m_sda_oe;
   wire m_ack = m_rx[0];

   always @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         m_st <= M_IDLE;
         m_q <= 2'h0;
         m_bit <= 4'h0;
         m_sh <= 9'h1FF;
         m_rx <= 9'h000;
         m_rd <= 1'b0;
         m_first <= 1'b0;
         m_left <= 8'h00;
         m_scl_oe <= 1'b0;
         m_sda_oe <= 1'b0;
         o_mst_wtake <= 1'b0;
         o_mst_rdata <= 8'h00;
         o_mst_rvalid <= 1'b0;
         o_mst_busy <= 1'b0;
         o_mst_nack <= 1'b0;
      end
      else
      begin
         o_mst_wtake <= 1'b0;
         o_mst_rvalid <= 1'b0;
         case (m_st)
            M_IDLE:
            begin
               m_scl_oe <= 1'b0;
               m_sda_oe <= 1'b0;
               if (i_mst_go & act_men & o_running)
               begin
                  m_st <= M_START;
                  m_q <= 2'h0;
                  m_rd <= i_mst_read;
                  m_left <= i_mst_len;
                  m_sh <= {i_mst_addr, i_mst_read, 1'b1};
                  o_mst_busy <= 1'b1;
                  o_mst_nack <= 1'b0;
               end
            end
            M_START:
               if (tick)
               begin
                  m_q <= m_q + 1'b1;
                  if (m_q == 2'h1)
                     m_sda_oe <= 1'b1;
                  if (m_q == 2'h2)
                  begin
                     m_scl_oe <= 1'b1;
                     m_bit <= 4'h0;
                     m_first <= 1'b1;
                     m_q <= 2'h0;
                     m_st <= M_BIT;
                  end
               end
            M_BIT:
               if (tick)
               begin
                  m_q <= m_q + 1'b1;
                  case (m_q)
                     2'h0: m_sda_oe <= ~m_sh[8];
                     2'h1: m_scl_oe <= 1'b0;
                     2'h2:
                        // a slave holding the clock low stretches the bit
                        if (~scl)
                           m_q <= m_q;
                        else
                           m_rx <= {m_rx[7:0], sda};
                     default:
                     begin
                        m_scl_oe <= 1'b1;
                        m_sh <= {m_sh[7:0], 1'b1};
                        m_bit <= m_bit + 1'b1;
                        if (m_bit == `IMS_BIT_ACK)
                        begin
                           m_bit <= 4'h0;
                           m_first <= 1'b0;
                           if (m_first & (m_ack | (m_left == 8'h00)))
                           begin
                              o_mst_nack <= m_ack;
                              m_st <= M_STOP;
                           end
                           else if (m_rd)
                           begin
                              if (~m_first)
                              begin
                                 o_mst_rdata <= m_rx[8:1];
                                 o_mst_rvalid <= 1'b1;
                                 m_left <= m_left - 1'b1;
                              end
                              if (~m_first & (m_left == 8'h01))
                                 m_st <= M_STOP;
                              // last byte of the read gets no acknowledge
                              else if (m_first)
                                 m_sh <= {8'hFF, m_left == 8'h01};
                              else
                                 m_sh <= {8'hFF, m_left == 8'h02};
                           end
                           else if (~m_first & m_ack)
                           begin
                              o_mst_nack <= 1'b1;
                              m_st <= M_STOP;
                           end
                           else if (~m_first & (m_left == 8'h01))
                              m_st <= M_STOP;
                           else
                           begin
                              if (~m_first)
                                 m_left <= m_left - 1'b1;
                              m_sh <= {i_mst_wdata, 1'b1};
                              o_mst_wtake <= 1'b1;
                           end
                        end
                     end
                  endcase
               end
            M_STOP:
               if (tick)
               begin
                  m_q <= m_q + 1'b1;
                  case (m_q)
                     2'h0: m_sda_oe <= 1'b1;
                     2'h1: m_scl_oe <= 1'b0;
                     2'h2: m_sda_oe <= 1'b0;
                     default:
                     begin
                        m_st <= M_IDLE;
                        o_mst_busy <= 1'b0;
                     end
                  endcase
               end
            default: m_st <= M_IDLE;
         endcase
      end
   end

   // slave fifos
   wire [7:0] txf_q;
   wire txf_ok;
   reg txf_pop;
   reg lg_pend;
   reg [11:0] lg_data;
   wire rx_ready;
   ims_fifo #(.WIDTH(`IMS_TX_W), .DEPTH(`IMS_FIFO_DEPTH),
      .AW(`IMS_FIFO_AW)) u_txf (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_in_data(i_txf_data),
      .i_in_valid(i_txf_valid),
      .o_in_ready(o_txf_ready),
      .o_out_data(txf_q),
      .o_out_valid(txf_ok),
      .i_out_ready(txf_pop)
   );
   ims_fifo #(.WIDTH(`IMS_LOG_W), .DEPTH(`IMS_FIFO_DEPTH),
      .AW(`IMS_FIFO_AW)) u_rxf (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_in_data(lg_data),
      .i_in_valid(lg_pend),
      .o_in_ready(rx_ready),
      .o_out_data(o_rxf_data),
      .o_out_valid(o_rxf_valid),
      .i_out_ready(i_rxf_ready)
   );

   // slave
   reg [5:0] s_st;
   reg [3:0] s_bc;
   reg [7:0] s_sh;
   reg [7:0] s_txb;
   reg [1:0] s_dwi;
   reg s_mack;
   reg s_hi10;
   reg s_dir;
   reg s_mark;
   reg s_sda_oe;
   reg s_hold;
   reg [7:0] dw_byte;
   wire s_act = o_running & act_sen;
   wire rise = scl & ~scl_d;
   wire fall = ~scl & scl_d;
   wire sta = scl & scl_d & sda_d & ~sda;
   wire sto = scl & scl_d & ~sda_d & sda;
   wire own7 = ~act_a10 & (s_sh[7:1] == act_addr[6:0]);
   wire own10 = act_a10 & (s_sh[7:1] == {`IMS_TEN_HDR, act_addr[9:8]});
   wire [7:0] next_txb = txf_ok ? txf_q : dw_byte;

   always @*
   begin
      case (s_dwi)
         2'h0: dw_byte = act_dw[31:24];
         2'h1: dw_byte = act_dw[23:16];
         2'h2: dw_byte = act_dw[15:8];
         default: dw_byte = act_dw[7:0];
      endcase
   end

   always @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         s_st <= S_IDLE;
         s_bc <= 4'h0;
         s_sh <= 8'h00;
         s_txb <= 8'h00;
         s_dwi <= 2'h0;
         s_mack <= 1'b1;
         s_hi10 <= 1'b0;
         s_dir <= 1'b0;
         s_mark <= 1'b0;
         s_sda_oe <= 1'b0;
         s_hold <= 1'b0;
         txf_pop <= 1'b0;
         lg_pend <= 1'b0;
         lg_data <= 12'h000;
      end
      else
      begin
         scl_d <= scl;
         sda_d <= sda;
         txf_pop <= 1'b0;
         // a full log stretches the clock rather than losing a byte
         s_hold <= lg_pend & ~rx_ready & ~(s_hold & rx_ready);
         if (lg_pend & rx_ready)
            lg_pend <= 1'b0;
         if (~s_act)
         begin
            s_st <= S_IDLE;
            s_sda_oe <= 1'b0;
            s_hi10 <= 1'b0;
         end
         else if (sta)
         begin
            s_st <= S_ADDR;
            s_bc <= 4'h0;
            s_sda_oe <= 1'b0;
            s_mark <= 1'b1;
            s_dwi <= 2'h0;
         end
         else if (sto)
         begin
            if (s_st != S_IDLE && s_st != S_IGN)
            begin
               lg_pend <= 1'b1;
               lg_data <= 12'h000;
               lg_data[`IMS_LOG_STOP] <= 1'b1;
            end
            s_st <= S_IDLE;
            s_sda_oe <= 1'b0;
            s_hi10 <= 1'b0;
         end
         else if (rise && s_st != S_IDLE)
         begin
            s_bc <= s_bc + 1'b1;
            if (s_bc < `IMS_BIT_ACK)
               s_sh <= {s_sh[6:0], sda};
            else
               s_mack <= sda;
         end
         else if (fall && s_st != S_IDLE && s_st != S_IGN)
         begin
            if (s_bc == `IMS_BIT_ACK)
            begin
               lg_data <= {s_mark, 1'b0, s_st == S_ADDR, s_dir, s_sh};
               case (s_st)
                  S_ADDR:
                     if (act_bm)
                     begin
                        s_dir <= s_sh[0];
                        lg_data[`IMS_LOG_RD] <= s_sh[0];
                        lg_pend <= 1'b1;
                        s_st <= S_WR;
                     end
                     else if (own7 | (own10 & (s_hi10 | ~s_sh[0])))
                     begin
                        s_sda_oe <= 1'b1;
                        s_dir <= s_sh[0];
                        lg_data[`IMS_LOG_RD] <= s_sh[0];
                        lg_pend <= ~(own10 & ~s_sh[0]);
                        s_st <= s_sh[0] ? S_RD :
                           ((own10 & ~s_sh[0]) ? S_ADDR2 : S_WR);
                     end
                     else
                        s_st <= S_IGN;
                  S_ADDR2:
                     if (s_sh == act_addr[7:0])
                     begin
                        s_sda_oe <= 1'b1;
                        s_hi10 <= 1'b1;
                        lg_data[`IMS_LOG_ADDR] <= 1'b1;
                        lg_pend <= 1'b1;
                        s_st <= S_WR;
                     end
                     else
                        s_st <= S_IGN;
                  S_WR:
                  begin
                     s_sda_oe <= ~act_bm;
                     lg_pend <= 1'b1;
                  end
                  default: s_sda_oe <= 1'b0;
               endcase
               s_mark <= 1'b0;
            end
            else if (s_bc == `IMS_BIT_END)
            begin
               s_bc <= 4'h0;
               s_sda_oe <= 1'b0;
               if (s_st == S_RD)
               begin
                  if (s_mack)
                     s_st <= S_IGN;
                  else
                  begin
                     // fifo bytes first, then the default word in order
                     s_sda_oe <= ~next_txb[7];
                     s_txb <= {next_txb[6:0], 1'b0};
                     txf_pop <= txf_ok;
                     if (~txf_ok)
                        s_dwi <= s_dwi + 1'b1;
                  end
               end
            end
            else if (s_st == S_RD)
            begin
               s_sda_oe <= ~s_txb[7];
               s_txb <= {s_txb[6:0], 1'b0};
            end
         end
      end
   end

   // open-drain pins: both ends share one wired-and bus
   always @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         o_scl_out <= 1'b0;
         o_sda_out <= 1'b0;
         o_scl_oe <= 1'b0;
         o_sda_oe <= 1'b0;
      end
      else
      begin
         o_scl_out <= 1'b0;
         o_sda_out <= 1'b0;
         o_scl_oe <= m_scl_oe | s_hold;
         o_sda_oe <= m_sda_oe | s_sda_oe;
      end
   end
endmodule // ims_port
`default_nettype wire

//--- inc/ims_consts.vh
`ifndef IMS_CONSTS_VH
`define IMS_CONSTS_VH
// system clock and the three bus bit periods
`define IMS_CLK_MHZ 125
`define IMS_T100K_NS 10000
`define IMS_T400K_NS 2500
`define IMS_T1M_NS 1000
// quarter bit period in clock cycles, rounded down
`define IMS_QTR(ns) ((ns) * `IMS_CLK_MHZ / 4000)
`define IMS_QW 10
`define IMS_RATE_100K 2'h0
`define IMS_RATE_400K 2'h1
`define IMS_RATE_1M 2'h2
// fifo geometry
`define IMS_FIFO_DEPTH 32
`define IMS_FIFO_AW 5
`define IMS_TX_W 8
`define IMS_LOG_W 12
// receive log entry markers above the data byte
`define IMS_LOG_START 11
`define IMS_LOG_STOP 10
`define IMS_LOG_ADDR 9
`define IMS_LOG_RD 8
// first byte prefix of a ten-bit address
`define IMS_TEN_HDR 5'h1E
`define IMS_BIT_ACK 4'h8
`define IMS_BIT_END 4'h9
`endif

//--- hdl/ims_sync.v
`timescale 1ns/1ns
`default_nettype none
module ims_sync #(
   parameter W = 2
) (
   input wire i_clock,
   input wire i_sys_rst,
   input wire [W-1:0] i_d,
   output reg [W-1:0] o_q
);
   reg [W-1:0] meta;
   always @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         meta <= {W{1'b1}};
         o_q <= {W{1'b1}};
      end
      else
      begin
         meta <= i_d;
         o_q <= meta;
      end
   end
endmodule // ims_sync
`default_nettype wire

//--- hdl/ims_fifo.v
`timescale 1ns/1ns
`default_nettype none
module ims_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   input wire i_clock,
   input wire i_sys_rst,
   input wire [WIDTH-1:0] i_in_data,
   input wire i_in_valid,
   output reg o_in_ready,
   output reg [WIDTH-1:0] o_out_data,
   output reg o_out_valid,
   input wire i_out_ready
);
   localparam [AW:0] FULL = DEPTH[AW:0];
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wp;
   reg [AW-1:0] rp;
   reg [AW:0] cnt;
   wire push = i_in_valid & o_in_ready;
   // output register refills when empty or being taken
   wire load = (cnt != {(AW+1){1'b0}}) & (~o_out_valid | i_out_ready);
   wire [AW:0] next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
   // the output register counts as a word, so the fifo holds DEPTH, not one more
   wire next_valid = load | (o_out_valid & ~i_out_ready);
   wire [AW:0] next_fill = next_cnt + {{AW{1'b0}}, next_valid};
   always @(posedge i_clock)
   begin
      if (push)
         mem[wp] <= i_in_data;
   end
   always @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         wp <= {AW{1'b0}};
         rp <= {AW{1'b0}};
         cnt <= {(AW+1){1'b0}};
         o_in_ready <= 1'b1;
         o_out_valid <= 1'b0;
         o_out_data <= {WIDTH{1'b0}};
      end
      else
      begin
         if (push)
            wp <= wp + 1'b1;
         if (load)
         begin
            o_out_data <= mem[rp];
            rp <= rp + 1'b1;
            o_out_valid <= 1'b1;
         end
         else if (i_out_ready)
            o_out_valid <= 1'b0;
         cnt <= next_cnt;
         o_in_ready <= (next_fill != FULL);
      end
   end
endmodule // ims_fifo
`default_nettype wire

//--- hdl/ims_unused_none.v
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

//--- testbench/ims_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
// open-drain bus with pull-ups; a released line floats high, never stale
module ims_bus_model (
   input wire logic i_scl_oe,
   input wire logic i_scl_out,
   input wire logic i_sda_oe,
   input wire logic i_sda_out,
   output logic o_scl,
   output logic o_sda
);
   assign o_scl = i_scl_oe ? i_scl_out : 1'b1;
   assign o_sda = i_sda_oe ? i_sda_out : 1'b1;
endmodule // ims_bus_model
`default_nettype wire

//--- testbench/ims_port_sva.sv
`timescale 1ns/1ns
`default_nettype none
module ims_port_chk (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_run,
   input wire logic i_cfg_store,
   input wire logic [9:0] i_own_addr,
   input wire logic [31:0] i_default_word,
   input wire logic i_mst_go,
   input wire logic i_rxf_ready,
   input wire logic o_scl_out,
   input wire logic o_scl_oe,
   input wire logic o_sda_out,
   input wire logic o_sda_oe,
   input wire logic [9:0] o_cfg_own_addr,
   input wire logic [31:0] o_cfg_default_word,
   input wire logic o_running,
   input wire logic o_mst_busy,
   input wire logic o_mst_rvalid,
   input wire logic o_mst_wtake,
   input wire logic [11:0] o_rxf_data,
   input wire logic o_rxf_valid
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   store_readback_a: assert property (i_cfg_store |=>
      o_cfg_own_addr == $past(i_own_addr) &&
      o_cfg_default_word == $past(i_default_word))
      else $error("readback differs from stored value");
   run_copy_a: assert property (!$past(i_sys_rst) |->
      o_running == $past(i_run)) else $error("running flag wrong");
   busy_cause_a: assert property ($rose(o_mst_busy) |->
      $past(o_running) && $past(i_mst_go))
      else $error("master started without go");
   rvalid_pulse_a: assert property (o_mst_rvalid |=>
      !o_mst_rvalid [*8]) else $error("read strobe too long");
   strobe_busy_a: assert property ((o_mst_rvalid || o_mst_wtake) |->
      o_mst_busy) else $error("byte strobe while idle");
   log_hold_a: assert property (o_rxf_valid && !i_rxf_ready |=>
      o_rxf_valid && $stable(o_rxf_data)) else $error("log entry lost");
   open_drain_a: assert property (!o_scl_out && !o_sda_out)
      else $error("pin driven high");
   stop_release_a: assert property ($fell(o_mst_busy) |->
      ##[0:4] (!o_scl_oe && !o_sda_oe)) else $error("bus held after stop");
endmodule // ims_port_chk
bind ims_port ims_port_chk u_ims_port_chk (.i_clock, .i_sys_rst, .i_run,
   .i_cfg_store, .i_own_addr, .i_default_word, .i_mst_go, .i_rxf_ready,
   .o_scl_out, .o_scl_oe, .o_sda_out, .o_sda_oe, .o_cfg_own_addr,
   .o_cfg_default_word, .o_running, .o_mst_busy, .o_mst_rvalid,
   .o_mst_wtake, .o_rxf_data, .o_rxf_valid);
`default_nettype wire

//--- testbench/ims_port_test.sv
`timescale 1ns/1ns
`default_nettype none
module ims_port_test;
   logic i_clock = 0, i_sys_rst = 1, i_cfg_store = 0, i_run = 0;
   logic [1:0] i_rate_sel = 2'h2;
   logic i_master_en = 1, i_slave_en = 1, i_bus_monitor_mode = 0;
   logic [9:0] i_own_addr = 10'h04A;
   logic i_addr10 = 0;
   logic [31:0] i_default_word = 32'h12345678;
   logic [7:0] i_txf_data = 0, i_mst_len = 0, i_mst_wdata = 0;
   logic i_txf_valid = 0, i_mst_go = 0, i_mst_read = 0, i_rxf_ready = 0;
   logic [6:0] i_mst_addr = 0;
   wire o_scl_out, o_scl_oe, o_sda_out, o_sda_oe, o_running, o_txf_ready;
   wire o_mst_wtake, o_mst_rvalid, o_mst_busy, o_mst_nack, o_rxf_valid;
   wire [1:0] o_cfg_rate;
   wire [9:0] o_cfg_own_addr;
   wire [31:0] o_cfg_default_word;
   wire [7:0] o_mst_rdata;
   wire [11:0] o_rxf_data;
   wire scl, sda;
   int err_count = 0, checks = 0;
   logic [7:0] rq[$];
   logic [11:0] lg[$];
   logic [7:0] wq[8] = '{8'hAA, 8'hBB, 8'hCC, 8'hDD, 0, 0, 0, 0};
   logic [7:0] exp8[8] = '{8'hAA, 8'hBB, 8'h12, 8'h34, 8'h56, 8'h78,
      8'h12, 8'h34};
   logic [11:0] expw[6] = '{12'hA94, 12'h0AA, 12'h0BB, 12'h0CC, 12'h0DD,
      12'h400};

   ims_bus_model u_ims_bus_model (.i_scl_oe(o_scl_oe), .i_scl_out(o_scl_out),
      .i_sda_oe(o_sda_oe), .i_sda_out(o_sda_out), .o_scl(scl), .o_sda(sda));
   ims_port u_ims_port (.i_clock, .i_sys_rst, .i_scl_in(scl), .o_scl_out,
      .o_scl_oe, .i_sda_in(sda), .o_sda_out, .o_sda_oe, .i_cfg_store,
      .i_rate_sel, .i_master_en, .i_slave_en, .i_bus_monitor_mode,
      .i_own_addr, .i_addr10, .i_default_word, .i_run, .o_cfg_rate,
      .o_cfg_master_en(), .o_cfg_slave_en(), .o_cfg_bus_monitor_mode(),
      .o_cfg_own_addr, .o_cfg_addr10(), .o_cfg_default_word, .o_running,
      .i_txf_data, .i_txf_valid, .o_txf_ready, .i_mst_go, .i_mst_read,
      .i_mst_addr, .i_mst_len, .i_mst_wdata, .o_mst_wtake, .o_mst_rdata,
      .o_mst_rvalid, .o_mst_busy, .o_mst_nack, .o_rxf_data, .o_rxf_valid,
      .i_rxf_ready);

   initial
   begin
      forever #4 i_clock = ~i_clock;
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task final_report;
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task cfg(input logic [9:0] a);
      i_own_addr <= a;
      i_cfg_store <= 1;
      @(posedge i_clock);
      i_cfg_store <= 0;
      repeat (2) @(posedge i_clock);
   endtask

   // holds valid across calls so back-to-back pushes need no idle cycle
   task push(input logic [7:0] d);
      i_txf_data <= d;
      i_txf_valid <= 1;
      do @(posedge i_clock); while (o_txf_ready !== 1'b1);
   endtask

   task xfer(input logic rd, input logic [6:0] a, input logic [7:0] n);
      int k, wi;
      logic seen;
      wi = 0;
      seen = 0;
      rq.delete();
      i_mst_read <= rd;
      i_mst_addr <= a;
      i_mst_len <= n;
      i_mst_wdata <= wq[0];
      i_mst_go <= 1;
      @(posedge i_clock);
      i_mst_go <= 0;
      for (k = 0; k < 60000 && !(seen && o_mst_busy === 1'b0); k++)
      begin
         @(posedge i_clock);
         if (o_mst_busy === 1'b1) seen = 1;
         if (o_mst_rvalid === 1'b1) rq.push_back(o_mst_rdata);
         if (o_mst_wtake === 1'b1)
         begin
            wi++;
            i_mst_wdata <= wq[wi % 8];
         end
      end
      chk({seen, o_mst_busy}, 2'b10);
   endtask

   task drain;
      lg.delete();
      i_rxf_ready <= 1;
      repeat (40)
      begin
         @(posedge i_clock);
         if (o_rxf_valid === 1'b1) lg.push_back(o_rxf_data);
      end
      i_rxf_ready <= 0;
   endtask

   // stop, store the current inputs and start again so they apply
   task restart;
      i_run <= 0;
      i_cfg_store <= 1;
      @(posedge i_clock);
      i_cfg_store <= 0;
      i_run <= 1;
      repeat (3) @(posedge i_clock);
   endtask

   initial
   begin
      repeat (16) @(posedge i_clock);
      i_sys_rst <= 0;
      @(posedge i_clock);
      chk(o_running, 0);
      cfg(10'h04A);
      chk(o_cfg_rate, 2);
      chk(o_cfg_own_addr, 10'h04A);
      chk(o_cfg_default_word, 32'h12345678);
      i_run <= 1;
      repeat (3) @(posedge i_clock);
      push(8'hAA);
      push(8'hBB);
      i_txf_valid <= 0;
      xfer(1, 7'h4A, 8);
      chk(rq.size(), 8);
      foreach (exp8[i]) chk(rq[i], exp8[i]);
      chk(o_mst_nack, 0);
      drain();
      chk(lg[0], 12'hB95);
      xfer(0, 7'h4A, 4);
      drain();
      chk(lg.size(), 6);
      foreach (expw[i]) chk(lg[i], expw[i]);
      xfer(1, 7'h33, 1);
      chk(o_mst_nack, 1);
      drain();
      // new address is stored but must wait for a restart
      cfg(10'h033);
      chk(o_cfg_own_addr, 10'h033);
      xfer(0, 7'h4A, 0);
      chk(o_mst_nack, 0);
      i_run <= 0;
      repeat (3) @(posedge i_clock);
      i_run <= 1;
      repeat (3) @(posedge i_clock);
      xfer(0, 7'h4A, 0);
      chk(o_mst_nack, 1);
      xfer(0, 7'h33, 0);
      chk(o_mst_nack, 0);
      drain();
      for (int i = 0; i < 32; i++) push(8'h40 + i[7:0]);
      i_txf_valid <= 0;
      repeat (2) @(posedge i_clock);
      chk(o_txf_ready, 0);
      i_rxf_ready <= 1;
      xfer(1, 7'h33, 33);
      for (int i = 0; i < 32; i++) chk(rq[i], 8'h40 + i);
      chk(rq[32], 8'h12);
      drain();
      // master switched off: a go must leave it idle
      i_own_addr <= 10'h0AA;
      i_addr10 <= 1;
      i_master_en <= 0;
      restart();
      i_mst_go <= 1;
      repeat (2) @(posedge i_clock);
      i_mst_go <= 0;
      @(posedge i_clock);
      chk(o_mst_busy, 0);
      i_master_en <= 1;
      restart();
      // ten-bit header for the upper bits, then the low byte as data
      xfer(0, 7'h78, 1);
      chk(o_mst_nack, 0);
      drain();
      chk(lg[0], 12'h2AA);
      i_bus_monitor_mode <= 1;
      restart();
      xfer(0, 7'h21, 1);
      chk(o_mst_nack, 1);
      drain();
      chk(lg[0], 12'hA42);
      final_report();
   end

   initial
   begin
      repeat (90000) @(posedge i_clock);
      err_count++;
      final_report();
   end
endmodule // ims_port_test
`default_nettype wire
